// ### verilog/ccfg_top.sv
// Function
// - Reset leaves PLL off, input through pre-divider.
// - Power field 01 powers down, 00 runs.
// - Pre-divider ratio resets to divide by four.
// - Bypass clear feeds distribution from pre-divider.
// - Source clear selects external clock input.
// - Pre-divider route divides by at least two.
// - New settings apply only after update write.
// - PLL with external input keeps VCO off.
// - Bypass set skips the pre-divider.
// - Source set selects the internal VCO.
`timescale 1ns/1ns
`default_nettype none
module ccfg_top
  import ccfg_pkg::*;
(
  // Clock and reset.
  input  wire logic               SYS_CLK,
  input  wire logic               RST_B,
  // APB slave.
  input  wire logic               PSEL,
  input  wire logic               PENABLE,
  input  wire logic               PWRITE,
  input  wire logic [ADDR_W-1:0]  PADDR,
  input  wire logic [31:0]        PWDATA,
  output logic      [31:0]        PRDATA,
  output logic                    PREADY,
  output logic                    PSLVERR,
  // Clock path controls.
  output logic                    PLL_PWR_DOWN,
  output logic                    VCO_PWR_ON,
  output logic                    PRESCALER_EXT_SEL,
  output logic                    DIST_SRC_VCO,
  output logic                    DIST_PREDIV_BYPASS,
  output logic      [2:0]         PREDIV_FACTOR
);

  logic             [IDX_W-1:0]   idx;
  logic                           aligned;
  logic                           hit_pwr;
  logic                           hit_div;
  logic                           hit_src;
  logic                           hit_upd;
  logic                           hit_stat;
  logic                           mapped;
  logic                           acc;
  logic                           setup;
  logic                           wr_ok;
  logic                           wr_go;
  logic                           upd_r;
  logic                           upd_nxt;
  logic                           upd_seen_r;
  logic             [REG_W-1:0]   stg_pwr;
  logic             [REG_W-1:0]   stg_div;
  logic             [REG_W-1:0]   stg_src;
  logic             [REG_W-1:0]   act_pwr;
  logic             [REG_W-1:0]   act_div;
  logic             [REG_W-1:0]   act_src;
  logic             [REG_W-1:0]   stat;
  logic             [REG_W-1:0]   rd_mux;
  logic             [31:0]        prdata_r;

  // Address decode; each register takes one aligned word at index * 4.
  assign idx      = PADDR[ADDR_W-1:2];
  assign aligned  = (PADDR[1:0] == 2'h0);
  assign hit_pwr  = aligned && (idx == PWR_IDX);
  assign hit_div  = aligned && (idx == PREDIV_IDX);
  assign hit_src  = aligned && (idx == SRC_IDX);
  assign hit_upd  = aligned && (idx == UPD_IDX);
  assign hit_stat = aligned && (idx == STAT_IDX);
  assign mapped   = hit_pwr || hit_div || hit_src || hit_upd || hit_stat;

  // Zero wait states; errors for unmapped addresses and status writes.
  assign setup   = PSEL && !PENABLE;
  assign acc     = PSEL && PENABLE;
  assign PREADY  = 1'b1;
  assign PSLVERR = acc && (!mapped || (PWRITE && hit_stat));
  assign wr_ok   = acc && PWRITE && mapped && !hit_stat;
  assign wr_go   = wr_ok && hit_upd && PWDATA[UPD_GO_BIT];

  // Update flag: set by the command write, cleared one cycle later.
  // A fresh command in the clearing cycle wins, so no update is lost.
  assign upd_nxt = wr_go;

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      upd_r <= 1'b0;
    end else begin
      upd_r <= upd_nxt;
    end
  end

  // Remembers that at least one update has been applied since reset.
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      upd_seen_r <= 1'b0;
    end else if (upd_r) begin
      upd_seen_r <= 1'b1;
    end
  end

  // Staged and active copies of the three settings registers.
  ccfg_stage_reg #(.W(REG_W), .RST(PWR_RST)) u_pwr (
    .clk      (SYS_CLK),
    .rst_b    (RST_B),
    .wr_en    (wr_ok && hit_pwr),
    .wr_data  (PWDATA[REG_W-1:0]),
    .load     (upd_r),
    .stage_q  (stg_pwr),
    .active_q (act_pwr)
  );

  ccfg_stage_reg #(.W(REG_W), .RST(PREDIV_RST)) u_div (
    .clk      (SYS_CLK),
    .rst_b    (RST_B),
    .wr_en    (wr_ok && hit_div),
    .wr_data  (PWDATA[REG_W-1:0]),
    .load     (upd_r),
    .stage_q  (stg_div),
    .active_q (act_div)
  );

  ccfg_stage_reg #(.W(REG_W), .RST(SRC_RST)) u_src (
    .clk      (SYS_CLK),
    .rst_b    (RST_B),
    .wr_en    (wr_ok && hit_src),
    .wr_data  (PWDATA[REG_W-1:0]),
    .load     (upd_r),
    .stage_q  (stg_src),
    .active_q (act_src)
  );

  // Clock path decode from the active settings.
  ccfg_route u_route (
    .clk        (SYS_CLK),
    .rst_b      (RST_B),
    .pwr        (act_pwr[PWR_LSB +: 2]),
    .ratio      (act_div[PREDIV_LSB +: 3]),
    .bypass     (act_src[SRC_BYP_BIT]),
    .src_vco    (act_src[SRC_VCO_BIT]),
    .pll_pd_r   (PLL_PWR_DOWN),
    .vco_on_r   (VCO_PWR_ON),
    .pre_ext_r  (PRESCALER_EXT_SEL),
    .dist_vco_r (DIST_SRC_VCO),
    .bypass_r   (DIST_PREDIV_BYPASS),
    .factor_r   (PREDIV_FACTOR)
  );

  // Status word showing the clock path actually in force.
  always_comb begin
    stat                              = '0;
    stat[STAT_PD_BIT]                 = PLL_PWR_DOWN;
    stat[STAT_VCO_BIT]                = VCO_PWR_ON;
    stat[STAT_PRE_BIT]                = PRESCALER_EXT_SEL;
    stat[STAT_DSRC_BIT]               = DIST_SRC_VCO;
    stat[STAT_BYP_BIT]                = DIST_PREDIV_BYPASS;
    stat[STAT_FAC_LSB +: 3]           = PREDIV_FACTOR;
  end

  // Read multiplexer; reads of settings return the staged values.
  always_comb begin
    rd_mux = '0;
    if (hit_pwr) begin
      rd_mux = stg_pwr;
    end else if (hit_div) begin
      rd_mux = stg_div;
    end else if (hit_src) begin
      rd_mux = stg_src;
    end else if (hit_upd) begin
      rd_mux[UPD_GO_BIT] = upd_r;
    end else if (hit_stat) begin
      rd_mux = stat;
    end
  end

  // Read data is captured in the setup cycle and held through the access.
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      prdata_r <= '0;
    end else if (setup && !PWRITE) begin
      prdata_r <= {{(32-REG_W){1'b0}}, rd_mux};
    end
  end

  assign PRDATA = prdata_r;

  // Checks run on the system clock and are off during reset.
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_B);

  // Until the first update the distribution-only default stands.
  reset_default_a: assert property (!upd_seen_r |->
    (PLL_PWR_DOWN && !DIST_SRC_VCO && !DIST_PREDIV_BYPASS && !VCO_PWR_ON))
    else $error("Default clock path not held before first update.");

  // PLL power output follows the active power field one cycle later.
  pll_power_a: assert property (1'b1 |=>
    (PLL_PWR_DOWN == ($past(act_pwr[PWR_LSB +: 2]) != PWR_NORMAL)))
    else $error("PLL power output does not match active field.");

  // Default pre-divider factor is four before any update.
  prediv_reset_a: assert property (!upd_seen_r |->
    (PREDIV_FACTOR == DIV_RST_FACT))
    else $error("Pre-divider factor is not the reset factor.");

  // The pre-divider never divides by less than two.
  div_min_a: assert property (PREDIV_FACTOR >= DIV_MIN)
    else $error("Pre-divider factor fell below two.");

  // Bypass and source outputs track the active source register.
  route_track_a: assert property (1'b1 |=>
    ((DIST_PREDIV_BYPASS == $past(act_src[SRC_BYP_BIT]))
      && (DIST_SRC_VCO == $past(act_src[SRC_VCO_BIT]))))
    else $error("Distribution routing does not match active source.");

  // Without an update the active settings do not move.
  update_hold_a: assert property (!upd_r |=>
    ($stable(act_pwr) && $stable(act_div) && $stable(act_src)))
    else $error("Active settings changed without an update.");

  // An update write reaches the clock path outputs three edges later.
  update_apply_a: assert property (wr_go |=> upd_r ##2
    ((PLL_PWR_DOWN == ($past(stg_pwr[PWR_LSB +: 2], 2) != PWR_NORMAL))
      && (DIST_SRC_VCO == $past(stg_src[SRC_VCO_BIT], 2))))
    else $error("Update write did not apply staged settings.");

  // PLL running on the external input keeps the VCO off.
  vco_off_a: assert property ((!PLL_PWR_DOWN && !DIST_SRC_VCO) |->
    (!VCO_PWR_ON && PRESCALER_EXT_SEL))
    else $error("VCO powered while PLL uses the external input.");

  // The update flag clears itself unless a new command arrives.
  self_clear_a: assert property ((upd_r && !wr_go) |=> !upd_r)
    else $error("Update flag did not clear itself.");

  // The update command always raises the flag at the next edge.
  upd_set_a: assert property (wr_go |=> upd_r)
    else $error("Update command did not raise the update flag.");

  // All three active copies load together from their staged values.
  update_all_a: assert property (upd_r |=>
    ((act_pwr == $past(stg_pwr)) && (act_div == $past(stg_div))
      && (act_src == $past(stg_src))))
    else $error("Active settings did not load together on update.");

  // An accepted write to the power register lands in its staged copy.
  stage_write_a: assert property ((wr_ok && hit_pwr) |=>
    (stg_pwr == $past(PWDATA[REG_W-1:0])))
    else $error("Staged power value differs from the written data.");

  // A write to an unmapped or unaligned address leaves every staged copy alone.
  refused_write_a: assert property ((acc && PWRITE && !mapped) |=>
    ($stable(stg_pwr) && $stable(stg_div) && $stable(stg_src)))
    else $error("Refused write changed a staged setting.");

  // A write to the status register is answered with an error.
  stat_refuse_a: assert property ((acc && PWRITE && hit_stat) |-> PSLVERR)
    else $error("Status write was not refused.");

  // A read of an unmapped address returns zero.
  refused_read_a: assert property ((acc && !PWRITE && !mapped) |-> (PRDATA == '0))
    else $error("Refused read returned nonzero data.");

  // Errors appear only in the access phase.
  slverr_phase_a: assert property (PSLVERR |-> acc)
    else $error("Error response outside the access phase.");

  // Read data above the register width is always zero.
  rdata_upper_a: assert property (PRDATA[31:REG_W] == '0)
    else $error("Read data has bits set above the register width.");

  // A powered-down PLL leaves the VCO off and the prescaler unfed.
  pll_off_path_a: assert property (PLL_PWR_DOWN |->
    (!VCO_PWR_ON && !PRESCALER_EXT_SEL))
    else $error("PLL path active while powered down.");

  // The VCO runs only with the PLL on and the VCO selected.
  vco_on_cond_a: assert property (VCO_PWR_ON |->
    (!PLL_PWR_DOWN && DIST_SRC_VCO))
    else $error("VCO powered without PLL on and VCO selected.");

  // The prescaler takes the external input only with the PLL on and that input selected.
  pre_ext_cond_a: assert property (PRESCALER_EXT_SEL |->
    (!PLL_PWR_DOWN && !DIST_SRC_VCO))
    else $error("Prescaler fed externally outside PLL external mode.");

  // The pre-divider factor never exceeds six.
  div_max_a: assert property (PREDIV_FACTOR <= DIV_MAX)
    else $error("Pre-divider factor above six.");

  // Main scenarios.
  upd_cov_c: cover property (wr_go ##3 !PLL_PWR_DOWN);
  clr_cov_c: cover property (upd_r ##1 !upd_r);
  vco_cov_c: cover property (VCO_PWR_ON && DIST_SRC_VCO);
  byp_cov_c: cover property (DIST_PREDIV_BYPASS && !DIST_SRC_VCO);
  err_cov_c: cover property (PSLVERR);

endmodule : ccfg_top
`default_nettype wire

// ### verilog/ccfg_pkg.sv
`default_nettype none
package ccfg_pkg;
  // APB address width; each register index sits at byte address index * 4.
  localparam int            ADDR_W        = 12;
  localparam int            IDX_W         = 10;
  localparam int            REG_W         = 8;
  // Register indices.
  localparam logic [9:0]    PWR_IDX       = 10'h010;
  localparam logic [9:0]    PREDIV_IDX    = 10'h1e0;
  localparam logic [9:0]    SRC_IDX       = 10'h1e1;
  localparam logic [9:0]    UPD_IDX       = 10'h232;
  localparam logic [9:0]    STAT_IDX      = 10'h233;
  // Reset values of the staged registers.
  localparam logic [7:0]    PWR_RST       = 8'h01;
  localparam logic [7:0]    PREDIV_RST    = 8'h02;
  localparam logic [7:0]    SRC_RST       = 8'h00;
  // Field layouts.
  localparam int            PWR_LSB       = 0;
  localparam logic [1:0]    PWR_NORMAL    = 2'h0;
  localparam logic [1:0]    PWR_DOWN      = 2'h1;
  localparam int            PREDIV_LSB    = 0;
  localparam int            SRC_BYP_BIT   = 0;
  localparam int            SRC_VCO_BIT   = 1;
  localparam int            UPD_GO_BIT    = 0;
  // Pre-divider code to factor mapping: factor = code + 2, codes above 4 clamp.
  localparam logic [2:0]    DIV_MIN       = 3'h2;
  localparam logic [2:0]    DIV_MAX       = 3'h6;
  localparam logic [2:0]    DIV_CODE_MAX  = 3'h4;
  localparam logic [2:0]    DIV_RST_FACT  = 3'(PREDIV_RST[2:0] + DIV_MIN);
  // Status register bit positions.
  localparam int            STAT_PD_BIT   = 0;
  localparam int            STAT_VCO_BIT  = 1;
  localparam int            STAT_PRE_BIT  = 2;
  localparam int            STAT_DSRC_BIT = 3;
  localparam int            STAT_BYP_BIT  = 4;
  localparam int            STAT_FAC_LSB  = 5;
endpackage : ccfg_pkg
`default_nettype wire

// ### verilog/ccfg_stage_reg.sv
`timescale 1ns/1ns
`default_nettype none
module ccfg_stage_reg
  import ccfg_pkg::*;
#(
  parameter int               W   = 8,
  parameter logic [W-1:0]     RST = '0
) (
  // Clock and reset.
  input  wire logic           clk,
  input  wire logic           rst_b,
  // Software write into the staged copy.
  input  wire logic           wr_en,
  input  wire logic [W-1:0]   wr_data,
  // Update command copies staged into active.
  input  wire logic           load,
  output logic      [W-1:0]   stage_q,
  output logic      [W-1:0]   active_q
);

  // Staged copy follows software writes only.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stage_q <= RST;
    end else if (wr_en) begin
      stage_q <= wr_data;
    end
  end

  // Active copy changes only on the update command.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      active_q <= RST;
    end else if (load) begin
      active_q <= stage_q;
    end
  end

  // The active copy takes exactly the staged value present at the load edge.
  stage_copy_a: assert property (@(posedge clk) disable iff (!rst_b)
    load |=> (active_q == $past(stage_q)))
    else $error("Active copy differs from staged value after load.");

endmodule : ccfg_stage_reg
`default_nettype wire

// ### verilog/ccfg_route.sv
`timescale 1ns/1ns
`default_nettype none
module ccfg_route
  import ccfg_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Active configuration fields.
  input  wire logic [1:0]  pwr,
  input  wire logic [2:0]  ratio,
  input  wire logic        bypass,
  input  wire logic        src_vco,
  // Registered clock path controls.
  output logic             pll_pd_r,
  output logic             vco_on_r,
  output logic             pre_ext_r,
  output logic             dist_vco_r,
  output logic             bypass_r,
  output logic      [2:0]  factor_r
);

  logic                    pll_on;
  logic             [2:0]  factor_nxt;

  // Only the normal code powers the PLL; every other code leaves it down.
  assign pll_on = (pwr == PWR_NORMAL);

  // Factor is code plus two, clamped so it never exceeds six.
  always_comb begin
    if (ratio > DIV_CODE_MAX) begin
      factor_nxt = DIV_MAX;
    end else begin
      factor_nxt = 3'(ratio + DIV_MIN);
    end
  end

  // Clock path controls, registered from the active fields.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pll_pd_r   <= 1'b1;
      vco_on_r   <= 1'b0;
      pre_ext_r  <= 1'b0;
      dist_vco_r <= 1'b0;
      bypass_r   <= 1'b0;
      factor_r   <= DIV_RST_FACT;
    end else begin
      pll_pd_r   <= !pll_on;
      vco_on_r   <= pll_on && src_vco;
      pre_ext_r  <= pll_on && !src_vco;
      dist_vco_r <= src_vco;
      bypass_r   <= bypass;
      factor_r   <= factor_nxt;
    end
  end

endmodule : ccfg_route
`default_nettype wire

// ### sim/ccfg_testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench
  import ccfg_pkg::*;
;
  // Byte addresses of the registers, index times four.
  localparam logic [ADDR_W-1:0] A_PWR  = {PWR_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] A_PRE  = {PREDIV_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] A_SRC  = {SRC_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] A_UPD  = {UPD_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] A_STAT = {STAT_IDX, 2'h0};
  // Bench signals and counters.
  logic              sys_clk = 1'b0;
  logic              rst_b   = 1'b0;
  logic              psel    = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite  = 1'b0;
  logic [ADDR_W-1:0] paddr   = '0;
  logic [31:0]       pwdata  = '0;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              pll_pd;
  logic              vco_on;
  logic              pre_ext;
  logic              dist_vco;
  logic              byp;
  logic [2:0]        factor;
  logic [7:0]        outs;
  int                mismatches  = 0;
  int                checks_done = 0;
  integer            seed        = 32'hd274;
  logic [23:0]       corner [4]  = '{24'h000200, 24'h010001, 24'h000702, 24'h030403};
  logic [7:0]        last_p, last_r, last_s;
  // Outputs packed in the same layout as the status register.
  assign outs = {factor, byp, dist_vco, pre_ext, vco_on, pll_pd};
  // Free-running 20 MHz clock.
  always #25 sys_clk = ~sys_clk;
  // Device under test.
  ccfg_top ccfg_top_i (
    .SYS_CLK(sys_clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .PLL_PWR_DOWN(pll_pd), .VCO_PWR_ON(vco_on), .PRESCALER_EXT_SEL(pre_ext),
    .DIST_SRC_VCO(dist_vco), .DIST_PREDIV_BYPASS(byp), .PREDIV_FACTOR(factor));
  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize
  // Compares one value and reports a mismatch at once.
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // Expected clock path controls for a given set of register values.
  function automatic logic [7:0] exp_out(input logic [7:0] p, input logic [7:0] r,
                                         input logic [7:0] s);
    logic       pd;
    logic [2:0] f;
    pd = (p[1:0] != 2'h0);
    f = (r[2:0] > 3'h4) ? 3'h6 : r[2:0] + 3'h2;
    return {f, s[0], s[1], ~pd & ~s[1], ~pd & s[1], pd};
  endfunction : exp_out
  // One APB transfer, entered at a rising edge; hold keeps PSEL for a back-to-back setup.
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] addr, input logic [31:0] wd,
                     input logic hold, output logic [31:0] rd, output logic err);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge sys_clk);
      if (pready === 1'b1) break;
    end
    if (n >= 50) begin
      mismatches++;
      $display("Error at %0t: ready got %h expected %h", $time, pready, 1'b1);
    end
    rd = prdata;
    err = pslverr;
    if (!hold) begin
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb
  // Write expecting acceptance.
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic hold);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, a, d, hold, rd, err);
    check({31'h0, err}, 32'h0);
  endtask : wr
  // Read with expected data and error flag.
  task automatic rdc(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input logic ex_err,
                     input logic hold);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, 32'h0, hold, rd, err);
    check(rd, exp);
    check({31'h0, err}, {31'h0, ex_err});
  endtask : rdc
  // Stages three settings, reads them back, updates and checks when outputs move.
  task automatic apply_cfg(input logic [7:0] p, input logic [7:0] r, input logic [7:0] s);
    logic [7:0] prev_outs;
    prev_outs = outs;
    last_p = p;
    last_r = r;
    last_s = s;
    wr(A_PWR, {24'h0, p}, 1'b1);
    wr(A_PRE, {24'h0, r}, 1'b1);
    wr(A_SRC, {24'h0, s}, 1'b1);
    rdc(A_PWR, {24'h0, p}, 1'b0, 1'b1);
    rdc(A_PRE, {24'h0, r}, 1'b0, 1'b1);
    rdc(A_SRC, {24'h0, s}, 1'b0, 1'b1);
    check({24'h0, outs}, {24'h0, prev_outs});
    wr(A_UPD, 32'h1, 1'b0);
    @(posedge sys_clk);
    #1 check({24'h0, outs}, {24'h0, prev_outs});
    @(posedge sys_clk);
    #1 check({24'h0, outs}, {24'h0, exp_out(p, r, s)});
    @(posedge sys_clk);
    rdc(A_STAT, {24'h0, exp_out(p, r, s)}, 1'b0, 1'b1);
    rdc(A_UPD, 32'h0, 1'b0, 1'b1);
  endtask : apply_cfg
  // Watchdog sized well beyond the expected run of about 640 cycles.
  initial begin
    #(50 * 20000);
    mismatches++;
    $display("Error at %0t: watchdog got %h expected %h", $time, 1'b1, 1'b0);
    summarize();
  end
  // Main sequence.
  initial begin
    logic [31:0] rd;
    logic        err;
    int          i;
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    #1 check({24'h0, outs}, 32'h81);
    @(posedge sys_clk);
    rdc(A_PWR, 32'h1, 1'b0, 1'b1);
    rdc(A_PRE, 32'h2, 1'b0, 1'b1);
    rdc(A_SRC, 32'h0, 1'b0, 1'b1);
    $display("Test reset done");
    for (i = 0; i < 4; i++) begin
      apply_cfg(corner[i][23:16], corner[i][15:8], corner[i][7:0]);
    end
    for (i = 0; i < 24; i++) begin
      apply_cfg(8'($random(seed)), 8'($random(seed)), 8'($random(seed)));
    end
    $display("Test staged update done");
    wr(A_UPD, 32'h1, 1'b1);
    rdc(A_UPD, 32'h1, 1'b0, 1'b0);
    @(posedge sys_clk);
    rdc(A_UPD, 32'h0, 1'b0, 1'b1);
    $display("Test update flag done");
    rdc(12'h004, 32'h0, 1'b1, 1'b1);
    apb(1'b1, A_PWR | 12'h001, 32'h2, 1'b1, rd, err);
    check({31'h0, err}, 32'h1);
    apb(1'b1, A_STAT, 32'hff, 1'b1, rd, err);
    check({31'h0, err}, 32'h1);
    rdc(A_STAT, {24'h0, exp_out(last_p, last_r, last_s)}, 1'b0, 1'b1);
    rdc(A_PWR, {24'h0, last_p}, 1'b0, 1'b0);
    $display("Test refusals done");
    @(posedge sys_clk);
    rst_b <= 1'b0;
    #1 check({24'h0, outs}, 32'h81);
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    rdc(A_PWR, 32'h1, 1'b0, 1'b0);
    $display("Test second reset done");
    summarize();
  end
endmodule : testbench
`default_nettype wire
